/* sac_ctrl.sv */
// Digital sequence control of a 4-channel simultaneous-sampling 12-bit converter.
// Assumes all pins synchronous to ref_clk; the analog core returns adc_code for conv_channel.
// Behaviour
// (RQ1) Busy rises on start, falls after last channel
// (RQ2) First-result flag high while pointer at first
// (RQ3) Start edge holds all four track-and-holds together
// (RQ4) Channel selection latched at start edge
// (RQ5) Chip select active low gates read, write
// (RQ6) Data drivers on only with read, select low
// (RQ7) Host keeps write strobe high during reads
// (RQ8) Write rising edge loads four low data lines
// (RQ9) Source low: hardware select pins give sequence
// (RQ10) Source high: software register gives sequence
// (RQ11) Standby input low stops conversion activity
// (RQ12) Ascending channel order; each read advances pointer (code: only reads while the FIFO holds a result)
// (RQ13) Register writes apply from next start edge
// (RQ14) Bit zero channel one, bit three channel four
// (RQ15) Short low pulse ends each conversion
// (RQ16) Each channel takes fourteen master clock ticks
// (RQ17) Clock select chooses internal or external clock
`timescale 1ns/100ps
`include "sac_defines.svh"
module sac_ctrl import sac_pkg::*; #(
    parameter int INT_DIV = `SAC_INT_DIV,
    parameter int FIFO_DEPTH = `SAC_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic convert_start,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] channel_mask_data_lines,
    input wire logic [3:0] hw_channel_select_pins,
    input wire logic select_source,
    input wire logic standby_n,
    input wire logic clock_source_select,
    input wire logic external_conversion_clock,
    input wire logic [`SAC_DATA_W-1:0] adc_code,
    output logic [`SAC_DATA_W-1:0] db_out,
    output logic db_oe,
    output logic busy,
    output logic eoc_n,
    output logic first_result_flag,
    output logic hold_all,
    output logic [1:0] conv_channel
);
    localparam logic [3:0] CONV_TICKS = 4'(`SAC_CONV_TICKS);
    localparam logic [4:0] EOC_CYC = 5'(`SAC_EOC_CYC);
    localparam int DW = $clog2(INT_DIV + 1);

    sac_fifo_if #(.W(`SAC_DATA_W)) fif ();

    sac_fifo #(.W(`SAC_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .f(fif)
    );

    sac_state_t state_q;
    sac_mask_t chan_sel_q;
    sac_mask_t seq_mask_q;
    logic [1:0] ch_q;
    logic [3:0] tick_cnt_q;
    logic [4:0] eoc_cnt_q;
    logic [2:0] rd_cnt_q;
    logic [DW-1:0] div_cnt_q;
    logic conv_prev_q;
    logic wr_prev_q;
    logic rd_prev_q;
    logic ext_prev_q;
    logic busy_q;
    logic hold_q;
    logic eoc_n_q;
    logic [`SAC_DATA_W-1:0] db_out_q;
    logic conv_rise;
    logic start;
    logic wr_load;
    logic rd_done;
    logic int_tick;
    logic ext_tick;
    logic mclk_tick;
    logic push_fire;
    sac_mask_t sel_mask;
    logic [2:0] first_ch;
    logic [2:0] next_ch;
    logic [4:0] ticks_seen_q;

    // Edge detection on host strobes and clocks
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            conv_prev_q <= 1'b0;
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
            ext_prev_q <= 1'b0;
        end else begin
            conv_prev_q <= convert_start;
            wr_prev_q <= wr_n;
            rd_prev_q <= rd_n;
            ext_prev_q <= external_conversion_clock;
        end
    end

    assign conv_rise = convert_start && !conv_prev_q;
    assign start = conv_rise && (state_q == ST_IDLE) && standby_n; // RQ3 RQ11
    assign wr_load = wr_n && !wr_prev_q && !cs_n && rd_n; // RQ5 RQ8
    assign rd_done = rd_n && !rd_prev_q && !cs_n; // RQ5
    assign sel_mask = select_source ? chan_sel_q : hw_channel_select_pins; // RQ9 RQ10
    assign first_ch = sac_next_ch(sel_mask, 3'h0); // RQ12
    assign next_ch = sac_next_ch(seq_mask_q, {1'b0, ch_q} + 3'h1); // RQ12

    // Master clock: divided internal oscillator or external clock edges
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt_q <= '0;
        end else if (div_cnt_q == DW'(INT_DIV - 1)) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    assign int_tick = (div_cnt_q == DW'(INT_DIV - 1));
    assign ext_tick = external_conversion_clock && !ext_prev_q;
    assign mclk_tick = clock_source_select ? ext_tick : int_tick; // RQ17

    // Software channel select register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan_sel_q <= `SAC_CHSEL_RST;
        end else if (wr_load) begin
            chan_sel_q <= channel_mask_data_lines; // RQ8 RQ14
        end
    end

    // Sequence state, channel and tick counting
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            seq_mask_q <= '0;
            ch_q <= '0;
            tick_cnt_q <= '0;
        end else if (!standby_n) begin
            state_q <= ST_IDLE; // RQ11
            tick_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start && !first_ch[2]) begin
                        state_q <= ST_CONV;
                        seq_mask_q <= sel_mask; // RQ4 RQ13
                        ch_q <= first_ch[1:0];
                        tick_cnt_q <= '0;
                    end
                end
                ST_CONV: begin
                    if (push_fire) begin
                        tick_cnt_q <= '0;
                        if (next_ch[2]) begin
                            state_q <= ST_IDLE;
                        end else begin
                            ch_q <= next_ch[1:0]; // RQ12
                        end
                    end else if (mclk_tick && (tick_cnt_q != CONV_TICKS)) begin
                        tick_cnt_q <= tick_cnt_q + 4'h1; // RQ16
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Busy and hold follow the sequence
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (!standby_n) begin
            busy_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (start && !first_ch[2]) begin
            busy_q <= 1'b1; // RQ1
            hold_q <= 1'b1; // RQ3
        end else if (push_fire && next_ch[2]) begin
            busy_q <= 1'b0; // RQ1
            hold_q <= 1'b0;
        end
    end

    // End-of-conversion pulse after each stored result
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            eoc_cnt_q <= '0;
            eoc_n_q <= 1'b1;
        end else if (push_fire) begin
            eoc_cnt_q <= EOC_CYC - 5'h1;
            eoc_n_q <= 1'b0; // RQ15
        end else if (eoc_cnt_q != '0) begin
            eoc_cnt_q <= eoc_cnt_q - 5'h1;
        end else begin
            eoc_n_q <= 1'b1;
        end
    end

    // Result path and read pointer
    assign fif.wr_valid = (state_q == ST_CONV) && (tick_cnt_q == CONV_TICKS) && standby_n; // RQ16
    assign fif.wr_data = adc_code;
    assign fif.clear = start;
    assign fif.rd_ready = rd_done; // RQ12
    assign push_fire = fif.wr_valid && fif.wr_ready;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_cnt_q <= '0;
        end else if (start) begin
            rd_cnt_q <= '0;
        end else if (rd_done && fif.rd_valid) begin
            rd_cnt_q <= rd_cnt_q + 3'h1; // RQ12
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            db_out_q <= '0;
        end else begin
            db_out_q <= fif.rd_valid ? fif.rd_data : '0;
        end
    end

    assign db_out = db_out_q;
    assign db_oe = !cs_n && !rd_n; // RQ6 RQ7
    assign busy = busy_q;
    assign eoc_n = eoc_n_q;
    assign first_result_flag = (rd_cnt_q == 3'h0); // RQ2
    assign hold_all = hold_q;
    assign conv_channel = ch_q;

    // Master ticks seen for the channel in progress, counted apart from tick_cnt_q
    // Never overruns: the FIFO cannot fill within one flushed sequence
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ticks_seen_q <= '0;
        end else if (start || push_fire || !standby_n) begin
            ticks_seen_q <= '0;
        end else if ((state_q == ST_CONV) && mclk_tick) begin
            ticks_seen_q <= ticks_seen_q + 5'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_busy_start: assert property (start && !first_ch[2] |=> busy && hold_all) // RQ1
        else $error("busy not raised by start");
    a_busy_end: assert property (push_fire && next_ch[2] |=> !busy && eoc_n == 1'b0) // RQ1
        else $error("busy not dropped after last channel");
    a_first_flag: assert property (rd_done && fif.rd_valid && !start |=> !first_result_flag) // RQ2
        else $error("first flag still high after read");
    a_first_start: assert property (start |=> first_result_flag) // RQ2
        else $error("first flag low after start");
    a_hold_tick: assert property (start && !first_ch[2] |=> hold_all && tick_cnt_q == 4'h0) // RQ3
        else $error("hold not entered at start");
    a_mask_stable: assert property (busy && $past(busy) |-> $stable(seq_mask_q)) // RQ4
        else $error("sequence mask changed mid sequence");
    a_oe_gate: assert property (cs_n || rd_n |-> !db_oe) // RQ6
        else $error("drivers on without select and read");
    a_reg_write: assert property (wr_load |=> chan_sel_q == $past(channel_mask_data_lines)) // RQ8
        else $error("channel select register not loaded");
    a_write_gate: assert property (cs_n |=> $stable(chan_sel_q)) // RQ5
        else $error("register written while deselected");
    a_hw_src: assert property (start && !select_source && state_q == ST_IDLE && hw_channel_select_pins != 4'h0
        |=> seq_mask_q == $past(hw_channel_select_pins)) // RQ9
        else $error("hardware selection not captured");
    a_sw_src: assert property (start && select_source && chan_sel_q != 4'h0 |=> seq_mask_q == $past(chan_sel_q)) // RQ10
        else $error("software selection not captured");
    a_standby_idle: assert property (!standby_n |=> !busy && !fif.wr_valid) // RQ11
        else $error("activity during standby");
    a_order_up: assert property (push_fire && !next_ch[2] |=> conv_channel > $past(conv_channel)) // RQ12
        else $error("channel order not ascending");
    a_eoc_width: assert property ($fell(eoc_n) |-> !eoc_n [*8]) // RQ15
        else $error("end of conversion pulse too short");
    a_conv_ticks: assert property (push_fire |-> ticks_seen_q == 5'(`SAC_CONV_TICKS)) // RQ16
        else $error("result stored before fourteen ticks");
    a_clk_source: assert property (state_q == ST_CONV && standby_n && clock_source_select && !ext_tick && !push_fire
        |=> $stable(tick_cnt_q)) // RQ17
        else $error("tick counted without external clock edge");

    c_full_seq: cover property (start && first_ch == 3'h0 && sel_mask == 4'hf);
    c_read_during: cover property (busy && rd_done && fif.rd_valid);
    c_ext_clock: cover property (push_fire && clock_source_select);
    c_standby_abort: cover property (busy && !standby_n);
endmodule

/* sac_defines.svh */
// Offsets-free constants for the simultaneous ADC sequence control block.
// Assumes a 200 MHz ref_clk; included by the controller file only.
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
`define SAC_CH_NUM 4
`define SAC_DATA_W 12
`define SAC_CONV_TICKS 14
`define SAC_CLK_MHZ 200
`define SAC_EOC_NS 75
`define SAC_EOC_CYC ((`SAC_EOC_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_INT_DIV 2
`define SAC_FIFO_DEPTH 16
`define SAC_CHSEL_RST 4'h0
`endif

/* sac_pkg.sv */
// Types and helpers shared by the sequence controller.
// Assumes nothing beyond the defines header.
package sac_pkg;
    typedef enum logic {ST_IDLE, ST_CONV} sac_state_t;
    typedef logic [3:0] sac_mask_t;

    // Lowest selected channel at or above 'from'; bit 2 set when none remains
    function automatic logic [2:0] sac_next_ch(input sac_mask_t mask, input logic [2:0] from);
        logic [2:0] r;
        r = 3'h4;
        for (int i = 3; i >= 0; i--) begin
            if (mask[i] && (3'(i) >= from)) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction
endpackage

/* sac_fifo_if.sv */
// Carrier between the controller and its result FIFO.
// Assumes both ends share ref_clk.
`timescale 1ns/100ps
interface sac_fifo_if #(parameter int W = 12);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    logic clear;
    modport ctl (output wr_valid, wr_data, rd_ready, clear, input wr_ready, rd_valid, rd_data);
    modport buf_side (input wr_valid, wr_data, rd_ready, clear, output wr_ready, rd_valid, rd_data);
endinterface

/* sac_fifo.sv */
// Result FIFO with valid/ready on both sides and a synchronous flush.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module sac_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    sac_fifo_if.buf_side f
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wptr_q;
    logic [AW:0] rptr_q;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign count = wptr_q - rptr_q;
    assign f.wr_ready = (count != (AW+1)'(DEPTH));
    assign f.rd_valid = (count != '0);
    assign f.rd_data = mem[rptr_q[AW-1:0]];
    assign push = f.wr_valid && f.wr_ready;
    assign pop = f.rd_ready && f.rd_valid;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wptr_q[AW-1:0]] <= f.wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else if (f.clear) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end
endmodule

/* sac_host_model.sv */
// Host processor model on the parallel bus: chip select, read and write strobes.
// Assumes the controller's ref_clk; every line changes on a falling edge.
`timescale 1ns/100ps
module sac_host_model (
    input wire logic ref_clk,
    input wire logic [11:0] db_out,
    input wire logic db_oe,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] dl
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        dl = 4'h5;
    end

    // Select line may be left high to make a refused access
    task automatic write_mask(input logic [3:0] m, input logic sel_n);
        @(negedge ref_clk);
        cs_n = sel_n;
        wr_n = 1'b0;
        dl = m;
        @(negedge ref_clk);
        wr_n = 1'b1;
        @(negedge ref_clk);
        cs_n = 1'b1;
        dl = ~m; // Released lines show no stale value
    endtask

    task automatic read_word(input logic sel_n, output logic [11:0] d, output logic oe);
        @(negedge ref_clk);
        cs_n = sel_n;
        rd_n = 1'b0;
        @(negedge ref_clk);
        oe = db_oe;
        d = db_out;
        rd_n = 1'b1;
        @(negedge ref_clk);
        cs_n = 1'b1;
        repeat (2) @(negedge ref_clk);
    endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the sequence controller with a host bus model.
// Assumes the design files are compiled first; analog result is a code per channel.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    import sac_pkg::*;
    logic ref_clk, nrst, convert_start, cs_n, rd_n, wr_n, select_source, standby_n;
    logic clock_source_select, external_conversion_clock, db_oe, busy, eoc_n, first_result_flag, hold_all;
    logic [3:0] dl, hw;
    logic [11:0] adc_code, db_out, d;
    logic [1:0] conv_channel;
    logic oe;
    logic [7:0] eoc_cnt, ticks;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    sac_ctrl #(.INT_DIV(2), .FIFO_DEPTH(16)) dut (.ref_clk(ref_clk), .nrst(nrst), .convert_start(convert_start),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .channel_mask_data_lines(dl), .hw_channel_select_pins(hw),
        .select_source(select_source), .standby_n(standby_n), .clock_source_select(clock_source_select),
        .external_conversion_clock(external_conversion_clock), .adc_code(adc_code), .db_out(db_out),
        .db_oe(db_oe), .busy(busy), .eoc_n(eoc_n), .first_result_flag(first_result_flag),
        .hold_all(hold_all), .conv_channel(conv_channel));
    sac_host_model host (.ref_clk(ref_clk), .db_out(db_out), .db_oe(db_oe), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .dl(dl));

    // Analog core stand-in: a distinct code for each channel
    assign adc_code = 12'h5a0 + {10'h000, conv_channel};

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(negedge eoc_n) eoc_cnt++;

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    task automatic start_seq();
        eoc_cnt = 8'h00;
        @(negedge ref_clk);
        convert_start = 1'b1;
        @(negedge ref_clk);
        convert_start = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 3000; i++) begin
            if (busy === 1'b0)
                break;
            @(negedge ref_clk);
        end
        `CHK("busy end", 1'b0, busy)
    endtask

    task automatic rd_chk(input logic [1:0] ch, input logic first);
        `CHK("first flag", first, first_result_flag)
        host.read_word(1'b0, d, oe);
        `CHK("oe", 1'b1, oe)
        `CHK("data", 12'h5a0 + {10'h000, ch}, d)
    endtask

    initial begin
        nrst = 1'b0;
        convert_start = 1'b0;
        hw = 4'h0;
        select_source = 1'b0;
        standby_n = 1'b1;
        clock_source_select = 1'b0;
        external_conversion_clock = 1'b0;
        eoc_cnt = 8'h00;
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        `CHK("busy rst", 1'b0, busy)
        `CHK("first rst", 1'b1, first_result_flag)
        `CHK("eoc rst", 1'b1, eoc_n)
        `CHK("oe idle", 1'b0, db_oe)
        // Empty hardware mask starts nothing
        start_seq();
        `CHK("busy empty", 1'b0, busy)
        // Hardware pins, changed while running
        hw = 4'ha;
        start_seq();
        `CHK("busy", 1'b1, busy)
        `CHK("hold", 1'b1, hold_all)
        `CHK("chan", 2'h1, conv_channel)
        hw = 4'hf;
        wait_idle();
        `CHK("hold end", 1'b0, hold_all)
        `CHK("eoc count", 8'h02, eoc_cnt)
        host.read_word(1'b1, d, oe);
        `CHK("oe unsel", 1'b0, oe)
        rd_chk(2'h1, 1'b1);
        rd_chk(2'h3, 1'b0);
        // Software register; an unselected write is ignored
        host.write_mask(4'h9, 1'b0);
        host.write_mask(4'h6, 1'b1);
        select_source = 1'b1;
        start_seq();
        `CHK("chan sw", 2'h0, conv_channel)
        host.write_mask(4'h2, 1'b0);
        wait_idle();
        `CHK("eoc count sw", 8'h02, eoc_cnt)
        rd_chk(2'h0, 1'b1);
        rd_chk(2'h3, 1'b0);
        start_seq();
        `CHK("chan next", 2'h1, conv_channel)
        wait_idle();
        `CHK("eoc count one", 8'h01, eoc_cnt)
        rd_chk(2'h1, 1'b1);
        // Standby aborts a run and blocks starts
        select_source = 1'b0;
        start_seq();
        repeat (10) @(negedge ref_clk);
        standby_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK("busy standby_n", 1'b0, busy)
        start_seq();
        `CHK("busy standby_n start", 1'b0, busy)
        standby_n = 1'b1;
        // External clock: stalled, then exactly counted ticks
        hw = 4'h1;
        clock_source_select = 1'b1;
        start_seq();
        repeat (60) @(negedge ref_clk);
        `CHK("busy ext stall", 1'b1, busy)
        ticks = 8'h00;
        while (eoc_n === 1'b1 && ticks < 8'd30) begin
            external_conversion_clock = 1'b1;
            repeat (2) @(negedge ref_clk);
            external_conversion_clock = 1'b0;
            repeat (2) @(negedge ref_clk);
            ticks++;
        end
        `CHK("ticks", 8'd14, ticks)
        wait_idle();
        rd_chk(2'h0, 1'b1);
        summarize();
    end
endmodule
